// ==== inc/line_power_pkg.sv ====
// Constants for the serial-line power controller.
// Assumes a 40 MHz core clock; times are converted to cycles here.
package line_power_pkg;

   localparam longint CLK_HZ         = 40000000;
   localparam longint IDLE_TIME_S    = 30;
   localparam longint WAKE_TIME_US   = 100;
   localparam longint IDLE_CYCLES    = IDLE_TIME_S * CLK_HZ;
   localparam longint WAKE_CYCLES    = (WAKE_TIME_US * CLK_HZ) / 1000000;

   // AXI4-Lite register map (byte addresses)
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;

   // CTRL field positions
   localparam int CTRL_VARIANT_BIT = 0;
   localparam int CTRL_USE_REG_BIT = 1;
   localparam int CTRL_WAKE_BIT    = 2;
   localparam int CTRL_SHUTDOWN_N_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h8;

   // STATUS field positions
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_READY_BIT  = 1;
   localparam int STAT_LEVEL_BIT  = 2;
   localparam int STAT_AUTO_BIT   = 3;
   localparam int STAT_WAKING_BIT = 4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      PWR_OFF,
      PWR_WAKING,
      PWR_ACTIVE
   } pwr_state_t;

endpackage : line_power_pkg

// ==== design/edge_sync.sv ====
// Two-flop synchroniser bank with change detection per bit.
// Assumes inputs are asynchronous to aclk.
`timescale 1ns/1ps
module edge_sync #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Raw and synchronised signals
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out,
   output logic                  any_change
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] stage_r;
   logic [WIDTH-1:0] prev_r;
   logic [WIDTH-1:0] diff;

   generate
      if (WIDTH < 1)
      begin : g_bad_width
         $error("edge_sync: width must be at least one");
      end
   endgenerate

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               meta_r[i]  <= 1'b0;
               stage_r[i] <= 1'b0;
               prev_r[i]  <= 1'b0;
            end
            else
            begin
               meta_r[i]  <= async_in[i];
               stage_r[i] <= meta_r[i];
               prev_r[i]  <= stage_r[i];
            end
         end
         assign diff[i] = stage_r[i] ^ prev_r[i];
      end
   endgenerate

   assign sync_out   = stage_r;
   assign any_change = |diff;

endmodule : edge_sync

// ==== design/line_power_ctrl.sv ====
// Power-mode controller of a multi-channel serial line transceiver.
// Assumes pins are asynchronous; software reaches it over AXI4-Lite.
`timescale 1ns/1ps

// Contract
// - Shutdown override low forces shutdown always (pin ignored while CTRL use-register bit set)
// - Auto mode only with shutdown high, wake low
// - Thirty idle seconds in auto shuts down
// - Any edge in auto wakes, restarts timer
// - Two-receiver variant: inverted, always active outputs
// - Three-state variant: outputs float when forced off
// - Three-state variant: extra non-inverting always-active output
// - Level-present high when any receiver valid
// - Level-present ignores both override inputs
// - Shutdown: pumps off, drivers float, ready low
// - Driver enable and ready delayed after wake
// - Wake tied to level-present: idle plus no level
// - Both tied to level-present: follows level only
// - Both-tied mode: three-state outputs float while off
// - Ready only once negative rail regulated
// - Drivers invert their logic inputs
module line_power_ctrl #(
   parameter int     N_RX        = 2,
   parameter int     N_TX        = 2,
   parameter longint IDLE_CYCLES = line_power_pkg::IDLE_CYCLES,
   parameter longint WAKE_CYCLES = line_power_pkg::WAKE_CYCLES
) (
   // Clock and reset
   input  wire logic            aclk,
   input  wire logic            aresetn,
   // Override pins
   input  wire logic            wake_override,
   input  wire logic            shutdown_override_n,
   // Line side
   input  wire logic [N_RX-1:0] rx_line,
   input  wire logic [N_RX-1:0] rx_level_ok,
   input  wire logic            pump_regulated,
   output logic      [N_TX-1:0] tx_line,
   output logic      [N_TX-1:0] tx_line_oe,
   output logic                 pump_enable,
   // Logic side
   input  wire logic [N_TX-1:0] tx_logic,
   output logic      [N_RX-1:0] rx_logic,
   output logic      [N_RX-1:0] rx_logic_oe,
   output logic                 ring_monitor_out,
   output logic                 level_present,
   output logic                 ready,
   // AXI4-Lite slave
   input  wire logic [7:0]      s_axi_awaddr,
   input  wire logic            s_axi_awvalid,
   output logic                 s_axi_awready,
   input  wire logic [31:0]     s_axi_wdata,
   input  wire logic [3:0]      s_axi_wstrb,
   input  wire logic            s_axi_wvalid,
   output logic                 s_axi_wready,
   output logic [1:0]           s_axi_bresp,
   output logic                 s_axi_bvalid,
   input  wire logic            s_axi_bready,
   input  wire logic [7:0]      s_axi_araddr,
   input  wire logic            s_axi_arvalid,
   output logic                 s_axi_arready,
   output logic [31:0]          s_axi_rdata,
   output logic [1:0]           s_axi_rresp,
   output logic                 s_axi_rvalid,
   input  wire logic            s_axi_rready
);

   localparam int NS = 2 * N_RX + N_TX + 2;
   localparam int CW = $clog2(IDLE_CYCLES + 1);
   localparam int WW = $clog2(WAKE_CYCLES + 1);

   generate
      if (N_RX < 2 || N_TX < 1 || IDLE_CYCLES < 1 || WAKE_CYCLES < 1)
      begin : g_bad_params
         $error("line_power_ctrl: unsupported parameter values");
      end
   endgenerate

   // Synchronised pins
   logic [NS-1:0]   sync_bus;
   logic            pin_change;
   logic [N_RX-1:0] rx_s;
   logic [N_RX-1:0] lvl_s;
   logic [N_TX-1:0] tx_s;
   logic            wake_s;
   logic            shutdown_n_s;
   logic            act_edge;

   edge_sync #(
      .WIDTH (NS)
   ) u_sync (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .async_in   ({shutdown_override_n, wake_override, rx_level_ok, tx_logic, rx_line}),
      .sync_out   (sync_bus),
      .any_change (pin_change)
   );

   assign rx_s         = sync_bus[N_RX-1:0];
   assign tx_s         = sync_bus[N_RX+N_TX-1:N_RX];
   assign lvl_s        = sync_bus[2*N_RX+N_TX-1:N_RX+N_TX];
   assign wake_s       = sync_bus[NS-2];
   assign shutdown_n_s = sync_bus[NS-1];

   // Data edges only; override pin changes are not line activity
   logic [N_RX+N_TX-1:0] data_prev_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         data_prev_r <= '0;
      else
         data_prev_r <= {tx_s, rx_s};
   end
   assign act_edge = pin_change && ({tx_s, rx_s} != data_prev_r);

   // Pump status is a pin too
   logic pump_meta_r;
   logic pump_s_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pump_meta_r <= 1'b0;
         pump_s_r    <= 1'b0;
      end
      else
      begin
         pump_meta_r <= pump_regulated;
         pump_s_r    <= pump_meta_r;
      end
   end

   // Control register
   logic [3:0] ctrl_r;
   logic       variant_3st;
   logic       eff_wake;
   logic       eff_shutdown_n;
   assign variant_3st = ctrl_r[line_power_pkg::CTRL_VARIANT_BIT];
   // Register copy of overrides lets software act as the sleep line
   assign eff_wake       = ctrl_r[line_power_pkg::CTRL_USE_REG_BIT] ?
                           ctrl_r[line_power_pkg::CTRL_WAKE_BIT] : wake_s;
   assign eff_shutdown_n = ctrl_r[line_power_pkg::CTRL_USE_REG_BIT] ?
                           ctrl_r[line_power_pkg::CTRL_SHUTDOWN_N_BIT] : shutdown_n_s;

   // Level-present derives from receiver levels alone
   logic level_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         level_r <= 1'b0;
      else
         level_r <= |lvl_s;
   end
   assign level_present = level_r;

   // Inactivity counter
   logic [CW-1:0] idle_cnt_r;
   logic          idle_expired;
   logic          auto_mode;
   assign auto_mode    = eff_shutdown_n && !eff_wake;
   assign idle_expired = (idle_cnt_r == CW'(IDLE_CYCLES));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         idle_cnt_r <= '0;
      else if (act_edge)
         idle_cnt_r <= '0;
      else if (!idle_expired)
         idle_cnt_r <= idle_cnt_r + CW'(1);
   end

   // Desired power: tied-override modes fall out of pin levels
   logic want_on;
   assign want_on = eff_shutdown_n && (eff_wake || !idle_expired);

   // Power state machine
   line_power_pkg::pwr_state_t state_r;
   logic [WW-1:0]              wake_cnt_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state_r <= line_power_pkg::PWR_OFF;
      else
      begin
         case (state_r)
            line_power_pkg::PWR_OFF:
               if (want_on)
                  state_r <= line_power_pkg::PWR_WAKING;
            line_power_pkg::PWR_WAKING:
               if (!want_on)
                  state_r <= line_power_pkg::PWR_OFF;
               else if (wake_cnt_r == WW'(WAKE_CYCLES - 1))
                  state_r <= line_power_pkg::PWR_ACTIVE;
            line_power_pkg::PWR_ACTIVE:
               if (!want_on)
                  state_r <= line_power_pkg::PWR_OFF;
            default:
               state_r <= line_power_pkg::PWR_OFF;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         wake_cnt_r <= '0;
      else if (state_r == line_power_pkg::PWR_WAKING)
         wake_cnt_r <= wake_cnt_r + WW'(1);
      else
         wake_cnt_r <= '0;
   end

   // Outputs from flops
   logic            pwr_on;
   logic            pump_en_r;
   logic [N_TX-1:0] tx_r;
   logic [N_TX-1:0] tx_oe_r;
   logic [N_RX-1:0] rx_r;
   logic [N_RX-1:0] rx_oe_r;
   logic            ring_r;
   logic            ready_r;
   assign pwr_on = (state_r == line_power_pkg::PWR_ACTIVE);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pump_en_r <= 1'b0;
         tx_r      <= '0;
         tx_oe_r   <= '0;
         ready_r   <= 1'b0;
      end
      else
      begin
         pump_en_r <= (state_r != line_power_pkg::PWR_OFF);
         tx_r      <= ~tx_s;
         tx_oe_r   <= {N_TX{pwr_on}};
         ready_r   <= pwr_on && pump_s_r;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_r    <= '0;
         rx_oe_r <= '0;
         ring_r  <= 1'b0;
      end
      else
      begin
         rx_r    <= ~rx_s;
         // Float only on the three-state part and only when forced off
         rx_oe_r <= {N_RX{!(variant_3st && !eff_shutdown_n)}};
         ring_r  <= rx_s[1];
      end
   end

   assign pump_enable      = pump_en_r;
   assign tx_line          = tx_r;
   assign tx_line_oe       = tx_oe_r;
   assign rx_logic         = rx_r;
   assign rx_logic_oe      = rx_oe_r;
   assign ring_monitor_out = ring_r;
   assign ready            = ready_r;

   // AXI4-Lite write side: address and data taken in either order
   logic       aw_held_r;
   logic       w_held_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic       bvalid_r;
   logic [1:0] bresp_r;
   logic       do_write;

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready  = !w_held_r && !bvalid_r;
   assign do_write      = aw_held_r && w_held_r && !bvalid_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         aw_addr_r <= '0;
         w_data_r  <= '0;
         w_strb_r  <= '0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         else if (do_write)
            aw_held_r <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         else if (do_write)
            w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= line_power_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_r <= 1'b1;
         bresp_r  <= (aw_addr_r[7:2] == line_power_pkg::CTRL_ADDR[7:2] ||
                      aw_addr_r[7:2] == line_power_pkg::STATUS_ADDR[7:2]) ?
                     line_power_pkg::RESP_OKAY : line_power_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl_r <= line_power_pkg::CTRL_RESET;
      else if (do_write && w_strb_r[0] &&
               aw_addr_r[7:2] == line_power_pkg::CTRL_ADDR[7:2])
         ctrl_r <= w_data_r[3:0];
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;

   // AXI4-Lite read side
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic [31:0] status_word;

   always_comb
   begin
      status_word = '0;
      status_word[line_power_pkg::STAT_ACTIVE_BIT] = pwr_on;
      status_word[line_power_pkg::STAT_READY_BIT]  = ready_r;
      status_word[line_power_pkg::STAT_LEVEL_BIT]  = level_r;
      status_word[line_power_pkg::STAT_AUTO_BIT]   = auto_mode;
      status_word[line_power_pkg::STAT_WAKING_BIT] =
         (state_r == line_power_pkg::PWR_WAKING);
   end

   assign s_axi_arready = !rvalid_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= line_power_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && !rvalid_r)
      begin
         rvalid_r <= 1'b1;
         rresp_r  <= line_power_pkg::RESP_OKAY;
         if (s_axi_araddr[7:2] == line_power_pkg::CTRL_ADDR[7:2])
            rdata_r <= {28'h0000000, ctrl_r};
         else if (s_axi_araddr[7:2] == line_power_pkg::STATUS_ADDR[7:2])
            rdata_r <= status_word;
         else
         begin
            rdata_r <= '0;
            rresp_r <= line_power_pkg::RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata  = rdata_r;
   assign s_axi_rresp  = rresp_r;

endmodule : line_power_ctrl

// ==== verification/line_power_props.sv ====
// Checker for the serial-line power controller, bound to its top module.
// Assumes the register override bit stays clear so the pins rule the power mode.
`timescale 1ns/1ps
module line_power_props #(
   parameter int     N_RX        = 2,
   parameter int     N_TX        = 2,
   parameter longint IDLE_CYCLES = 200,
   parameter longint WAKE_CYCLES = 10
) (
   // Clock and reset
   input wire logic            aclk,
   input wire logic            aresetn,
   // Pins
   input wire logic            wake_override,
   input wire logic            shutdown_override_n,
   input wire logic [N_RX-1:0] rx_line,
   input wire logic [N_RX-1:0] rx_level_ok,
   input wire logic            pump_regulated,
   input wire logic [N_TX-1:0] tx_line,
   input wire logic [N_TX-1:0] tx_line_oe,
   input wire logic            pump_enable,
   input wire logic [N_TX-1:0] tx_logic,
   input wire logic [N_RX-1:0] rx_logic,
   input wire logic            ring_monitor_out,
   input wire logic            level_present,
   input wire logic            ready
);
   logic [2:0]      up_r;
   logic [31:0]     idle_r;
   logic [31:0]     on_r;
   logic [N_TX-1:0] tx_prev_r;
   logic [N_RX-1:0] rx_prev_r;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   always_ff @(posedge aclk)
   begin
      up_r <= !aresetn ? 3'h0 : up_r + 3'(up_r != 3'h7);
      on_r <= (aresetn && wake_override && shutdown_override_n) ? on_r + 32'h1 : 32'h0;
   end

   // Restarts on raw edges; the design sees them later, hence the margin below
   always_ff @(posedge aclk)
   begin
      tx_prev_r <= tx_logic;
      rx_prev_r <= rx_line;
      if (!aresetn || wake_override || !shutdown_override_n || tx_logic != tx_prev_r
          || rx_line != rx_prev_r)
         idle_r <= 32'h0;
      else
         idle_r <= idle_r + 32'h1;
   end

   sequence s_quiet;
      up_r == 3'h7 && $stable(tx_logic) && $stable(rx_line) && $stable(rx_level_ok);
   endsequence
   sequence s_wake_hold;
      (tx_line_oe == '0 && !ready) [*8];
   endsequence

   a_off_forced: assert property ((!shutdown_override_n) [*7] |->
      tx_line_oe == '0 && !pump_enable && !ready) else $error("forced shutdown ignored");
   a_on_forced: assert property (on_r > WAKE_CYCLES + 10 |->
      pump_enable && tx_line_oe == '1) else $error("forced wake ignored");
   a_idle_off: assert property (idle_r > IDLE_CYCLES + 10 |->
      tx_line_oe == '0 && !pump_enable) else $error("idle shutdown missing");
   a_wake_hold: assert property ($rose(pump_enable) |-> s_wake_hold)
      else $error("drivers enabled too early");
   a_ready_gate: assert property (ready |-> tx_line_oe == '1)
      else $error("ready while drivers off");
   a_ready_pump: assert property ((!pump_regulated) [*4] |-> !ready)
      else $error("ready without regulated rail");
   a_tx_invert: assert property (s_quiet [*4] |-> tx_line == ~tx_logic)
      else $error("driver output not inverted");
   a_rx_invert: assert property (s_quiet [*4] |-> rx_logic == ~rx_line)
      else $error("receiver output not inverted");
   a_ring_copy: assert property (s_quiet [*4] |-> ring_monitor_out == rx_line[1])
      else $error("ring monitor wrong");
   a_level_any: assert property (s_quiet [*4] |-> level_present == |rx_level_ok)
      else $error("level flag wrong");
endmodule : line_power_props

bind line_power_ctrl line_power_props #(
   .N_RX(N_RX), .N_TX(N_TX), .IDLE_CYCLES(IDLE_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)
) u_props (
   .aclk, .aresetn, .wake_override, .shutdown_override_n, .rx_line, .rx_level_ok,
   .pump_regulated, .tx_line, .tx_line_oe, .pump_enable, .tx_logic, .rx_logic,
   .ring_monitor_out, .level_present, .ready
);

// ==== verification/remote_line_model.sv ====
// Remote equipment at the far end of the serial cable.
// Assumes two receivers; it answers only while our drivers are on.
`timescale 1ns/1ps
module remote_line_model (
   // Clock
   input  wire logic       aclk,
   // Scenario controls
   input  wire logic       carrier,
   input  wire logic       answer,
   input  wire logic       slow,
   // Cable
   input  wire logic [1:0] tx_line_oe,
   output logic      [1:0] rx_line,
   output logic      [1:0] rx_level_ok
);
   logic [4:0] gap_r;

   initial
   begin
      gap_r = 5'h00;
      rx_line = 2'h3;
   end

   assign rx_level_ok = {2{carrier}};

   always @(posedge aclk)
   begin
      gap_r <= gap_r + 5'h01;
      // Cable open: input pull-downs leave the line at mark
      if (!carrier)
         rx_line <= 2'h3;
      // Levels held long enough for quiet-line checks; bit 1 toggles each step, bit 0 only when bit 1 was high
      else if (answer && tx_line_oe != 2'h0 && gap_r >= (slow ? 5'h10 : 5'h06))
      begin
         rx_line <= rx_line ^ {1'b1, rx_line[1]};
         gap_r <= 5'h00;
      end
   end
endmodule : remote_line_model

// ==== verification/line_power_ctrl_tb.sv ====
// Self-checking bench for the serial-line power controller.
// Assumes short idle and wake counts; the pump rail settles four cycles after enable.
`timescale 1ns/1ps
module line_power_ctrl_tb;
   localparam int         IDLE = 200;
   localparam int         WAKE = 10;
   localparam logic [1:0] OK   = line_power_pkg::RESP_OKAY;
   localparam logic [1:0] ERR  = line_power_pkg::RESP_SLVERR;
   localparam logic [7:0] CTRL = line_power_pkg::CTRL_ADDR;
   localparam logic [7:0] STAT = line_power_pkg::STATUS_ADDR;
   logic        aclk, aresetn, wake_override, shutdown_override_n, pump_regulated;
   logic        pump_enable, ring_monitor_out, level_present, ready;
   logic        carrier, answer, slow, sleep_request_n;
   logic [1:0]  rx_line, rx_level_ok, tx_line, tx_line_oe, tx_logic, rx_logic, rx_logic_oe;
   logic [1:0]  tie, bresp, rresp;
   logic [2:0]  pump_sh;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [33:0] bus_q[$];
   logic [6:0]  pin_q[$];
   event        pin_ev;
   int          n_fail, checks_done;

   line_power_ctrl #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(WAKE)) u_line_power_ctrl (
      .aclk, .aresetn, .wake_override, .shutdown_override_n, .rx_line, .rx_level_ok,
      .pump_regulated, .tx_line, .tx_line_oe, .pump_enable, .tx_logic, .rx_logic,
      .rx_logic_oe, .ring_monitor_out, .level_present, .ready,
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   remote_line_model u_remote_line_model (
      .aclk, .carrier, .answer, .slow, .tx_line_oe, .rx_line, .rx_level_ok);

   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   always @(posedge aclk)
   begin
      pump_sh <= {pump_sh[1:0], pump_enable};
      pump_regulated <= pump_sh[2] & pump_enable;
      if (tie == 2'h1 || tie == 2'h2) wake_override <= level_present;
      if (tie == 2'h2) shutdown_override_n <= level_present;
      if (tie == 2'h3) {wake_override, shutdown_override_n} <= {2{sleep_request_n}};
      if (rvalid && rready) cmp_bus({rresp, rdata}, bus_q.pop_front());
      if (bvalid && bready) cmp_bus({bresp, 32'h0}, bus_q.pop_front());
   end

   always @(pin_ev) cmp_pin({rx_logic_oe, tx_line_oe, pump_enable, ready, level_present},
                            pin_q.pop_front());

   task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: bus %h, expected %h", $time, got, exp);
      end
   endtask : cmp_bus

   task automatic cmp_pin(input logic [6:0] got, input logic [6:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: pins %b, expected %b", $time, got, exp);
      end
   endtask : cmp_pin

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bus_q.push_back({r, 32'h0});
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (awvalid && !awready || wvalid && !wready);
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bus_q.push_back({r, d});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
   endtask : rd

   task automatic see(input int n, input logic [6:0] exp);
      repeat (n) @(posedge aclk);
      pin_q.push_back(exp);
      -> pin_ev;
   endtask : see

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      $display("Error at %0t: run hung", $time);
      tally_and_finish();
   end

   initial
   begin
      {aresetn, carrier, answer, slow, awvalid, wvalid, bready, arvalid, rready} = '0;
      {wake_override, shutdown_override_n, sleep_request_n} = 3'h5;
      {tie, tx_logic, pump_sh, pump_regulated, n_fail, checks_done} = '0;
      {awaddr, araddr, wdata} = '0;
      void'($urandom(32'h5912121F));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CTRL, 32'(line_power_pkg::CTRL_RESET), OK);
      wr(8'h10, 32'h0000000F, ERR);
      rd(8'h10, 32'h0, ERR);
      see(20, 7'h60);
      rd(STAT, 32'h0, OK);
      carrier <= 1'b1;
      shutdown_override_n <= 1'b1;
      see(WAKE + 25, 7'h7F);
      rd(STAT, 32'h7, OK);
      wr(CTRL, 32'h9, OK);
      rd(CTRL, 32'h9, OK);
      shutdown_override_n <= 1'b0;
      see(12, 7'h01);
      {carrier, wake_override, shutdown_override_n} <= 3'h1;
      see(IDLE + 30, 7'h60);
      tx_logic <= tx_logic ^ 2'($urandom_range(3, 1));
      see(WAKE + 15, 7'h7E);
      see(IDLE + 30, 7'h60);
      {carrier, answer, wake_override} <= 3'h7;
      slow <= 1'($urandom);
      see(WAKE + 25, 7'h7F);
      wake_override <= 1'b0;
      see(IDLE + 30, 7'h7F);
      answer <= 1'b0;
      tie <= 2'h1;
      see(WAKE + 25, 7'h7F);
      carrier <= 1'b0;
      tx_logic <= tx_logic ^ 2'($urandom_range(3, 1));
      see(IDLE / 2, 7'h7E);
      see(IDLE, 7'h60);
      carrier <= 1'b1;
      tie <= 2'h2;
      see(WAKE + 25, 7'h7F);
      carrier <= 1'b0;
      tx_logic <= tx_logic ^ 2'($urandom_range(3, 1));
      see(15, 7'h00);
      tie <= 2'h3;
      sleep_request_n <= 1'b0;
      see(15, 7'h00);
      sleep_request_n <= 1'b1;
      see(WAKE + 25, 7'h7E);
      tally_and_finish();
   end
endmodule : line_power_ctrl_tb
